// File: verilog/strap_pkg.sv
// Shared constants and types for the strap latch and pin role block
package strap_pkg;
  // Register byte addresses on the Wishbone bus
  localparam logic [7:0] WB_STRAP   = 8'h00;
  localparam logic [7:0] WB_STATUS  = 8'h04;
  localparam logic [7:0] WB_MASK    = 8'h08;
  localparam logic [7:0] WB_PHYCTL  = 8'h0C;
  localparam logic [7:0] WB_PINCFG  = 8'h10;
  // Management register numbers
  localparam logic [4:0] REG_INT    = 5'h1B;
  localparam logic [4:0] REG_PHYCTL = 5'h1F;
  // Management frame opcodes and bit counts
  localparam logic [1:0] OP_WR      = 2'h1;
  localparam logic [1:0] OP_RD      = 2'h2;
  localparam logic [4:0] HDR_LAST   = 5'h0C;
  localparam logic [4:0] DATA_LAST  = 5'h0F;
  // Field positions
  localparam int POL_BIT  = 14;
  localparam int WOL_BIT  = 7;
  localparam int PME_BIT  = 0;
  // Mode strap codes, fixed address high bits and PHYCTL reset value
  localparam logic [3:0] MODE_NAND  = 4'h4;
  localparam logic [3:0] MODE_PDOWN = 4'h7;
  localparam logic [1:0] MODE_RGMII = 2'h3;
  localparam logic [1:0] ADDR_HI    = 2'h0;
  localparam logic [15:0] PHYCTL_RST = 16'h0000;

  typedef enum logic [1:0] {
    OP_RESERVED,
    OP_NAND,
    OP_PDOWN,
    OP_RGMII
  } op_mode_e;

  typedef enum logic [1:0] {
    M_IDLE,
    M_HDR,
    M_TA,
    M_DATA
  } mdio_e;
endpackage

// File: verilog/strap_sync.sv
// Two-stage synchroniser for pins entering the system clock domain
module strap_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_i,  // Synchronous reset
  input  wire logic [W-1:0] d_i,    // Asynchronous inputs
  output logic      [W-1:0] q_o     // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  always_comb begin
    st_next.meta = d_i;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.sync;
endmodule

// File: verilog/strap_latch_pin_roles.sv
// Strap capture, shared pin roles, interrupt pin and management access
// Functional notes
// RULE1: Receive data pins are latched as the four mode strap bits in reset.
// RULE2: The receive clock pin is latched as management address bit 2.
// RULE3: The receive control pin is latched as reference clock enable.
// RULE4: In RGMII mode the strap pins carry RD3..RD0, RX_CTL and RXC.
// RULE5: The MAC drives TX_CTL into the transmit enable input.
// RULE6: The management data line is sampled and driven on the MDC clock.
// RULE7: Register 1Bh sets the interrupt conditions and shows the status.
// RULE8: The interrupt pin is active low unless bit 14 of 1Fh is set.
// RULE9: In wake option the shared pin goes low on a wake-on-LAN event.
// RULE10: The interrupt pin is always driven to both levels.
// RULE11: At 1000 Mb/s pair D carries BI_DD for MDI, BI_DC for MDI-X.
// RULE12: Mode 0100 is NAND tree, 0111 power-down, 11xx RGMII.
// RULE13: Straps are taken at the rising edge of the reset pin.
// RULE14: Address bits 4 and 3 are always zero.
// RULE15: The strap enables or disables the reference clock output.
// RULE16: Strap pins stay undriven in reset and until straps are held.
//
// Our own choices: the Wishbone slave port and the address map.
module strap_latch_pin_roles #(
  parameter logic [1:0] ADDR_LOW = 2'h0
) (
  input  wire logic        clk_i,                 // 40 MHz clock
  input  wire logic        rst_i,                 // Sync reset
  input  wire logic        hw_reset_n_i,          // Reset pin, low active
  input  wire logic [3:0]  op_select_strap_i,     // RXD pins in
  output logic      [3:0]  rxd_o,                 // RXD pins out
  output logic             rxd_oe_o,              // RXD drive enable
  input  wire logic        rx_control_pin_i,      // RX_CTL pin in
  output logic             rx_control_pin_o,      // RX_CTL pin out
  output logic             rx_control_pin_oe_o,   // RX_CTL drive enable
  input  wire logic        mgmt_addr_strap_b2_i,  // RXC pin in
  output logic             rx_clk_pin_o,          // RXC pin out
  output logic             rx_clk_pin_oe_o,       // RXC drive enable
  input  wire logic [3:0]  rgmii_rxd_i,           // Core receive data
  input  wire logic        rgmii_rx_ctl_i,        // Core receive control
  input  wire logic        rgmii_rxc_i,           // Core receive clock
  input  wire logic        mdc_i,                 // Management clock pin
  input  wire logic        mdio_i,                // Management data in
  output logic             mdio_o,                // Management data out
  output logic             mdio_oe_o,             // Management drive
  input  wire logic [6:0]  event_i,               // Core event pulses
  input  wire logic        wol_i,                 // Wake event pulse
  output logic             wake_event_output_o,   // Interrupt/wake pin
  input  wire logic        speed_1000_i,          // Gigabit link
  input  wire logic        mdix_i,                // Crossover selected
  input  wire logic        bi_dd_i,               // Pair D symbol
  input  wire logic        bi_dc_i,               // Pair C symbol
  output logic             media_pair_d_pos_o,    // Pair D plus
  output logic             media_pair_d_neg_o,    // Pair D minus
  output logic             media_pair_d_oe_o,     // Pair D active
  output logic [4:0]       mgmt_addr_o,           // Management address
  output logic [1:0]       op_mode_o,             // Decoded mode
  output logic [1:0]       adv_sel_o,             // Advertised set
  output logic             ref_clk_oe_o,          // Ref clock enable
  output logic             straps_valid_o,        // Straps captured
  output logic             irq_o,                 // Interrupt, high
  input  wire logic        wb_cyc_i,              // Wishbone cycle
  input  wire logic        wb_stb_i,              // Wishbone strobe
  input  wire logic        wb_we_i,               // Wishbone write
  input  wire logic [7:0]  wb_adr_i,              // Byte address
  input  wire logic [3:0]  wb_sel_i,              // Byte selects
  input  wire logic [31:0] wb_dat_i,              // Write data
  output logic [31:0]      wb_dat_o,              // Read data
  output logic             wb_ack_o               // Acknowledge
);
  typedef struct packed {
    logic                rst_n_prev;
    logic                mdc_prev;
    logic                captured;
    logic [3:0]          mode;
    logic [4:0]          addr;
    logic                clk_en;
    strap_pkg::op_mode_e op;
    logic [1:0]          adv;
    logic [7:0]          status;
    logic [7:0]          mask;
    logic [15:0]         ctrl;
    logic                pme_sel;
    logic                irq;
    logic                pin;
    logic                wb_ack;
    logic [31:0]         wb_dat;
    logic [3:0]          rxd;
    logic                rxd_oe;
    logic                rxctl;
    logic                rxc;
    logic                pd_pos;
    logic                pd_neg;
    logic                pd_oe;
    strap_pkg::mdio_e    mst;
    logic [4:0]          cnt;
    logic [15:0]         sh;
    logic                rd;
    logic                wr;
    logic [4:0]          regsel;
    logic                mdio_out;
    logic                mdio_oe;
  } st_s;

  st_s        st_reg;
  st_s        st_next;
  logic [8:0] sq;
  logic [3:0] s_rxd;
  logic       s_rxctl;
  logic       s_rxc;
  logic       s_mdc;
  logic       s_mdio;
  logic       s_rst_n;
  logic       rst_rise;
  logic       mdc_rise;

  strap_sync #(
    .W (9)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({hw_reset_n_i, mdio_i, mdc_i, mgmt_addr_strap_b2_i,
             rx_control_pin_i, op_select_strap_i}),
    .q_o   (sq)
  );

  assign s_rxd    = sq[3:0];
  assign s_rxctl  = sq[4];
  assign s_rxc    = sq[5];
  assign s_mdc    = sq[6];
  assign s_mdio   = sq[7];
  assign s_rst_n  = sq[8];
  assign rst_rise = s_rst_n & ~st_reg.rst_n_prev;
  assign mdc_rise = s_mdc & ~st_reg.mdc_prev;

  always_comb begin
    logic [12:0] hdr;
    logic [15:0] rv;
    logic [15:0] wd;
    logic [7:0]  clr;
    logic        act;
    logic        sel;
    logic        req;
    hdr = '0;
    rv  = '0;
    wd  = '0;
    clr = '0;
    act = 1'b0;
    sel = 1'b0;
    req = wb_cyc_i & wb_stb_i & ~st_reg.wb_ack;
    st_next = st_reg;
    st_next.rst_n_prev = s_rst_n;
    st_next.mdc_prev   = s_mdc;

    // Strap capture at reset pin release
    if (!s_rst_n) begin
      st_next.captured = 1'b0;
    end else if (rst_rise) begin // RULE13
      st_next.captured = 1'b1;
      st_next.mode     = s_rxd; // RULE1
      st_next.addr     = {strap_pkg::ADDR_HI, s_rxc, ADDR_LOW}; // RULE2 RULE14
      st_next.clk_en   = s_rxctl; // RULE3
    end
    if (st_next.mode == strap_pkg::MODE_NAND) begin // RULE12
      st_next.op = strap_pkg::OP_NAND;
    end else if (st_next.mode == strap_pkg::MODE_PDOWN) begin
      st_next.op = strap_pkg::OP_PDOWN;
    end else if (st_next.mode[3:2] == strap_pkg::MODE_RGMII) begin
      st_next.op = strap_pkg::OP_RGMII;
    end else begin
      st_next.op = strap_pkg::OP_RESERVED;
    end
    st_next.adv = (st_next.op == strap_pkg::OP_RGMII) ?
                  st_next.mode[1:0] : 2'h0;

    // Shared pins turn into RGMII outputs one cycle after capture
    st_next.rxd_oe = (st_reg.op == strap_pkg::OP_RGMII) &
                     st_reg.captured & s_rst_n; // RULE16
    st_next.rxd    = rgmii_rxd_i; // RULE4
    st_next.rxctl  = rgmii_rx_ctl_i;
    st_next.rxc    = rgmii_rxc_i;

    // Wishbone slave, one registered ack per request, one cycle after the strobe
    st_next.wb_ack = req;
    if (req) begin
      st_next.wb_dat = '0;
      if (wb_we_i) begin
        if (wb_adr_i == strap_pkg::WB_STATUS) begin
          clr = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
        end else if (wb_adr_i == strap_pkg::WB_MASK) begin
          if (wb_sel_i[0]) st_next.mask = wb_dat_i[7:0];
        end else if (wb_adr_i == strap_pkg::WB_PHYCTL) begin
          if (wb_sel_i[0]) st_next.ctrl[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) st_next.ctrl[15:8] = wb_dat_i[15:8];
        end else if (wb_adr_i == strap_pkg::WB_PINCFG) begin
          if (wb_sel_i[0]) st_next.pme_sel = wb_dat_i[strap_pkg::PME_BIT];
        end
      end else begin
        if (wb_adr_i == strap_pkg::WB_STRAP) begin
          st_next.wb_dat = {19'h0, st_reg.op, st_reg.clk_en, st_reg.addr,
                            st_reg.mode, st_reg.captured};
        end else if (wb_adr_i == strap_pkg::WB_STATUS) begin
          st_next.wb_dat = {24'h0, st_reg.status};
        end else if (wb_adr_i == strap_pkg::WB_MASK) begin
          st_next.wb_dat = {24'h0, st_reg.mask};
        end else if (wb_adr_i == strap_pkg::WB_PHYCTL) begin
          st_next.wb_dat = {16'h0, st_reg.ctrl};
        end else if (wb_adr_i == strap_pkg::WB_PINCFG) begin
          st_next.wb_dat = {31'h0, st_reg.pme_sel};
        end
      end
    end

    // Management frame slave on synchronised MDC rising edges
    if (st_reg.regsel == strap_pkg::REG_INT) begin // RULE7
      rv = {st_reg.mask, st_reg.status};
    end else if (st_reg.regsel == strap_pkg::REG_PHYCTL) begin
      rv = st_reg.ctrl;
    end
    hdr = {st_reg.sh[11:0], s_mdio};
    wd  = {st_reg.sh[14:0], s_mdio};
    case (st_reg.mst)
      strap_pkg::M_IDLE: begin
        if (mdc_rise && !s_mdio) begin // RULE6
          st_next.mst = strap_pkg::M_HDR;
          st_next.cnt = '0;
        end
      end
      strap_pkg::M_HDR: begin
        if (mdc_rise) begin
          st_next.sh  = wd;
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt == strap_pkg::HDR_LAST) begin
            st_next.cnt    = '0;
            st_next.regsel = hdr[4:0];
            st_next.rd     = hdr[12] && hdr[9:5] == st_reg.addr &&
                             hdr[11:10] == strap_pkg::OP_RD;
            st_next.wr     = hdr[12] && hdr[9:5] == st_reg.addr &&
                             hdr[11:10] == strap_pkg::OP_WR;
            st_next.mst    = hdr[12] ? strap_pkg::M_TA : strap_pkg::M_IDLE;
          end
        end
      end
      strap_pkg::M_TA: begin
        if (mdc_rise) begin
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt == 5'h00) begin
            st_next.mdio_oe  = st_reg.rd;
            st_next.mdio_out = 1'b0;
          end else begin
            st_next.mst      = strap_pkg::M_DATA;
            st_next.cnt      = '0;
            st_next.mdio_out = st_reg.rd & rv[15];
            st_next.sh       = {rv[14:0], 1'b0};
          end
        end
      end
      strap_pkg::M_DATA: begin
        if (mdc_rise) begin
          st_next.cnt      = st_reg.cnt + 5'h01;
          st_next.sh       = st_reg.rd ? {st_reg.sh[14:0], 1'b0} : wd;
          st_next.mdio_out = st_reg.rd & st_reg.sh[15];
          if (st_reg.cnt == strap_pkg::DATA_LAST) begin
            st_next.mst      = strap_pkg::M_IDLE;
            st_next.mdio_oe  = 1'b0;
            st_next.mdio_out = 1'b0;
            st_next.rd       = 1'b0;
            st_next.wr       = 1'b0;
            if (st_reg.wr && st_reg.regsel == strap_pkg::REG_INT) begin
              st_next.mask = wd[15:8]; // RULE7
            end else if (st_reg.wr &&
                         st_reg.regsel == strap_pkg::REG_PHYCTL) begin
              st_next.ctrl = wd; // RULE8
            end
          end
        end
      end
      default: begin
        st_next.mst = strap_pkg::M_IDLE;
      end
    endcase

    // Sticky events, a set beats a clear in the same cycle
    st_next.status = (st_reg.status & ~clr) | {wol_i, event_i};
    act = |(st_next.status & st_next.mask);
    st_next.irq = act;
    if (st_next.pme_sel) begin
      st_next.pin = ~st_next.status[strap_pkg::WOL_BIT]; // RULE9
    end else begin
      st_next.pin = st_next.ctrl[strap_pkg::POL_BIT] ? act : ~act; // RULE8
    end

    // Pair D carries DD or DC at gigabit, idle otherwise
    sel = mdix_i ? bi_dc_i : bi_dd_i;
    st_next.pd_oe  = speed_1000_i; // RULE11
    st_next.pd_pos = speed_1000_i & sel;
    st_next.pd_neg = speed_1000_i & ~sel;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.pin  <= 1'b1;
      st_reg.ctrl <= strap_pkg::PHYCTL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rxd_o               = st_reg.rxd;
  assign rxd_oe_o            = st_reg.rxd_oe;
  assign rx_control_pin_o    = st_reg.rxctl;
  assign rx_control_pin_oe_o = st_reg.rxd_oe;
  assign rx_clk_pin_o        = st_reg.rxc;
  assign rx_clk_pin_oe_o     = st_reg.rxd_oe;
  assign mdio_o              = st_reg.mdio_out;
  assign mdio_oe_o           = st_reg.mdio_oe;
  assign wake_event_output_o = st_reg.pin; // RULE10
  assign media_pair_d_pos_o  = st_reg.pd_pos;
  assign media_pair_d_neg_o  = st_reg.pd_neg;
  assign media_pair_d_oe_o   = st_reg.pd_oe;
  assign mgmt_addr_o         = st_reg.addr;
  assign op_mode_o           = st_reg.op;
  assign adv_sel_o           = st_reg.adv;
  assign ref_clk_oe_o        = st_reg.clk_en; // RULE15
  assign straps_valid_o      = st_reg.captured;
  assign irq_o               = st_reg.irq;
  assign wb_dat_o            = st_reg.wb_dat;
  assign wb_ack_o            = st_reg.wb_ack;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mode_capture: assert property (rst_rise |=> // RULE1
    st_reg.mode == $past(s_rxd)) else $error("mode strap not latched");
  a_addr_capture: assert property (rst_rise |=> // RULE2
    mgmt_addr_o[2] == $past(s_rxc)) else $error("address strap wrong");
  a_refclk_capture: assert property (rst_rise |=> // RULE3
    ref_clk_oe_o == $past(s_rxctl)) else $error("clock enable strap wrong");
  a_rgmii_drive: assert property (rxd_oe_o |-> // RULE4
    op_mode_o == strap_pkg::OP_RGMII && $past(straps_valid_o))
    else $error("strap pins driven outside RGMII mode");
  a_mdio_edge: assert property ($rose(mdio_oe_o) |-> // RULE6
    $past(mdc_rise) && st_reg.mst == strap_pkg::M_TA)
    else $error("management drive not on MDC edge");
  a_irq_cause: assert property ((event_i[0] && st_reg.mask[0]) |=> // RULE7
    irq_o && st_reg.status[0]) else $error("event did not raise irq");
  a_int_polarity: assert property (!st_reg.pme_sel |-> // RULE8
    wake_event_output_o == (st_reg.ctrl[strap_pkg::POL_BIT] ? irq_o : !irq_o))
    else $error("interrupt pin polarity wrong");
  a_wake_low: assert property ((st_reg.pme_sel && wol_i) |=> // RULE9
    !wake_event_output_o) else $error("wake event not shown low");
  a_pair_idle: assert property (!speed_1000_i |=> // RULE11
    !media_pair_d_oe_o && !media_pair_d_pos_o && !media_pair_d_neg_o)
    else $error("pair D active below gigabit");
  a_mode_decode: assert property ( // RULE12
    (st_reg.mode == strap_pkg::MODE_PDOWN) |->
    op_mode_o == strap_pkg::OP_PDOWN) else $error("mode decode wrong");
  a_addr_high: assert property (mgmt_addr_o[4:3] == 2'h0) // RULE14
    else $error("address high bits not zero");
  a_pins_quiet: assert property (!$past(s_rst_n) |-> !rxd_oe_o) // RULE16
    else $error("strap pins driven in reset");

  c_strap_capture: cover property (rst_rise ##1 straps_valid_o);
  c_mdio_read: cover property (st_reg.mst == strap_pkg::M_DATA && st_reg.rd);
  c_wake_pin: cover property (st_reg.pme_sel && !wake_event_output_o);
  c_wb_write: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o);
endmodule

// File: dv/mgmt_master_model.sv
// Management master model: clock and data frames on the MDC/MDIO link
module mgmt_master_model (
  input  wire logic clk_i,     // System clock
  input  wire logic mdio_i,    // Resolved data line
  output logic      mdc_o,     // Management clock
  output logic      mdio_o,    // Data driven by master
  output logic      mdio_oe_o  // Master drives data line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock stands low between frames
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // Preamble, start, opcode, address, register, turnaround, data
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [35:0] bits;
    bits = {4'hF, 2'h1, op, phy, rg, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 35; i >= 0; i--) begin
      @(posedge clk_i);
      mdc_o <= 1'b0;
      mdio_o <= bits[i];
      mdio_oe_o <= (op == strap_pkg::OP_WR) || (i > 17);
      repeat (4) @(posedge clk_i);
      mdc_o <= 1'b1;
      if (i < 16) rd[i] = mdio_i;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
    repeat (16) @(posedge clk_i);
  endtask
endmodule

// File: dv/strap_latch_pin_roles_tb_top.sv
// Bench: strap capture, pin roles, interrupt pin, management frames
module strap_latch_pin_roles_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] A_LOW = 2'h2;
  localparam int         LIMIT = 20000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hw_reset_n_i = 1'b0;
  logic [3:0]  pull_mode = 4'h0;
  logic        pull_clken = 1'b0;
  logic        pull_b2 = 1'b0;
  logic [9:0]  lvl = 10'h000;
  logic [6:0]  event_i = 7'h00;
  logic        wol_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0]  rxd_o;
  logic [4:0]  mgmt_addr_o;
  logic [1:0]  op_mode_o, adv_sel_o;
  logic [31:0] wb_dat_o;
  logic        rxd_oe_o, ctl_o, ctl_oe_o, rxc_o, rxc_oe_o, mdio_o, mdio_oe_o;
  logic        pin_o, pos_o, neg_o, pd_oe_o, ref_oe_o, valid_o, irq_o, ack_o;
  logic        mdc, m_do, m_oe;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  // Shared pins show the pulled level while undriven
  wire logic [3:0] op_pin = rxd_oe_o ? rxd_o : pull_mode;
  wire logic       ctl_pin = ctl_oe_o ? ctl_o : pull_clken;
  wire logic       rxc_pin = rxc_oe_o ? rxc_o : pull_b2;
  wire logic       mdio_w = m_oe ? m_do : (mdio_oe_o ? mdio_o : 1'b1);

  strap_latch_pin_roles #(.ADDR_LOW(A_LOW)) u_strap_latch_pin_roles (
    .clk_i, .rst_i, .hw_reset_n_i, .op_select_strap_i(op_pin), .rxd_o,
    .rxd_oe_o, .rx_control_pin_i(ctl_pin), .rx_control_pin_o(ctl_o),
    .rx_control_pin_oe_o(ctl_oe_o), .mgmt_addr_strap_b2_i(rxc_pin),
    .rx_clk_pin_o(rxc_o), .rx_clk_pin_oe_o(rxc_oe_o),
    .rgmii_rxd_i(lvl[3:0]), .rgmii_rx_ctl_i(lvl[4]), .rgmii_rxc_i(lvl[5]),
    .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o, .mdio_oe_o, .event_i, .wol_i,
    .wake_event_output_o(pin_o), .speed_1000_i(lvl[6]), .mdix_i(lvl[7]),
    .bi_dd_i(lvl[8]), .bi_dc_i(lvl[9]), .media_pair_d_pos_o(pos_o),
    .media_pair_d_neg_o(neg_o), .media_pair_d_oe_o(pd_oe_o), .mgmt_addr_o,
    .op_mode_o, .adv_sel_o, .ref_clk_oe_o(ref_oe_o),
    .straps_valid_o(valid_o), .irq_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o(ack_o));

  mgmt_master_model u_mgmt_master_model (
    .clk_i, .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_do), .mdio_oe_o(m_oe));

  always #12.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [1:0] exp_mode(input logic [3:0] c);
    if (c == strap_pkg::MODE_NAND) return strap_pkg::OP_NAND;
    if (c == strap_pkg::MODE_PDOWN) return strap_pkg::OP_PDOWN;
    if (c[3:2] == strap_pkg::MODE_RGMII) return strap_pkg::OP_RGMII;
    return strap_pkg::OP_RESERVED;
  endfunction

  task automatic chk_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Classic single Wishbone cycle, held until acknowledged
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    {wol_i, event_i} <= v;
    @(posedge clk_i);
    {wol_i, event_i} <= 8'h00;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] q;
    logic [15:0] m;
    logic [4:0]  phy;
    logic [7:0]  ev;
    void'($urandom(46921));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk_bit("pin_idle", 1'b1, pin_o);
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_i);
      hw_reset_n_i <= 1'b0;
      pull_mode <= 4'(c);
      pull_clken <= 1'($urandom);
      pull_b2 <= 1'($urandom);
      repeat (6) @(posedge clk_i);
      #1 chk_bit("rxd_oe_rst", 1'b0, rxd_oe_o);
      @(posedge clk_i);
      hw_reset_n_i <= 1'b1;
      do @(posedge clk_i); while (valid_o !== 1'b1);
      phy = {2'b00, pull_b2, A_LOW};
      #1 chk_word("mode", 32'(exp_mode(pull_mode)), 32'(op_mode_o));
      chk_word("adv", 32'(pull_mode[3:2] == strap_pkg::MODE_RGMII ?
               pull_mode[1:0] : 2'h0), 32'(adv_sel_o));
      chk_word("addr", 32'(phy), 32'(mgmt_addr_o));
      chk_bit("ref_clk", pull_clken, ref_oe_o);
      wb(1'b0, strap_pkg::WB_STRAP, 32'h0, q);
      chk_word("strap", {19'h0, exp_mode(pull_mode), pull_clken, phy,
               pull_mode, 1'b1}, q);
      chk_bit("rxd_oe", c >= 12, rxd_oe_o);
    end
    repeat (40) begin
      r = $urandom;
      @(posedge clk_i);
      lvl <= r[9:0];
      @(posedge clk_i);
      #1 chk_word("rxd", 32'(r[3:0]), 32'(op_pin));
      chk_bit("rx_ctl", r[4], ctl_pin);
      chk_bit("rxc", r[5], rxc_pin);
      chk_bit("pair_oe", r[6], pd_oe_o);
      if (r[6]) chk_bit("pair_pos", r[7] ? r[9] : r[8], pos_o);
      if (r[6]) chk_bit("pair_neg", r[7] ? !r[9] : !r[8], neg_o);
    end
    wb(1'b1, strap_pkg::WB_MASK, 32'h0000_00FF, q);
    ev = 8'(1 << $urandom_range(6, 0));
    pulse(ev);
    #1 chk_bit("irq_set", 1'b1, irq_o);
    chk_bit("pin_low", 1'b0, pin_o);
    wb(1'b0, strap_pkg::WB_STATUS, 32'h0, q);
    chk_word("status", 32'(ev), q);
    wb(1'b1, strap_pkg::WB_PHYCTL, 32'h0000_4000, q);
    repeat (3) @(posedge clk_i);
    #1 chk_bit("pin_high", 1'b1, pin_o);
    u_mgmt_master_model.frame(strap_pkg::OP_RD, phy, strap_pkg::REG_INT,
                              16'h0000, m);
    chk_word("mgmt_int", {16'h0, 8'hFF, ev}, {16'h0, m});
    wb(1'b1, strap_pkg::WB_STATUS, 32'(ev), q);
    repeat (3) @(posedge clk_i);
    #1 chk_bit("irq_clr", 1'b0, irq_o);
    chk_bit("pin_drv0", 1'b0, pin_o);
    u_mgmt_master_model.frame(strap_pkg::OP_WR, phy, strap_pkg::REG_INT,
                              16'h0000, m);
    wb(1'b0, strap_pkg::WB_MASK, 32'h0, q);
    chk_word("mask", 32'h0, q);
    pulse(8'h7F);
    #1 chk_bit("irq_masked", 1'b0, irq_o);
    wb(1'b1, strap_pkg::WB_STATUS, 32'h0000_007F, q);
    r = $urandom;
    u_mgmt_master_model.frame(strap_pkg::OP_WR, phy, strap_pkg::REG_PHYCTL,
                              r[15:0], m);
    wb(1'b0, strap_pkg::WB_PHYCTL, 32'h0, q);
    chk_word("phyctl", {16'h0, r[15:0]}, q);
    #1 chk_bit("pin_pol", !r[14], pin_o);
    wb(1'b1, strap_pkg::WB_PINCFG, 32'h0000_0001, q);
    repeat (3) @(posedge clk_i);
    #1 chk_bit("wake_idle", 1'b1, pin_o);
    pulse(8'h80);
    #1 chk_bit("wake_low", 1'b0, pin_o);
    wb(1'b1, strap_pkg::WB_STATUS, 32'h0000_0080, q);
    repeat (3) @(posedge clk_i);
    #1 chk_bit("wake_rel", 1'b1, pin_o);
    u_mgmt_master_model.frame(strap_pkg::OP_RD, phy ^ 5'h01,
                              strap_pkg::REG_PHYCTL, 16'h0000, m);
    chk_word("other_phy", 32'h0000_FFFF, {16'h0, m});
    wb(1'b0, 8'h20, 32'h0, q);
    chk_word("unmapped", 32'h0, q);
    end_sim();
  end
endmodule
